// *** hw/boot_lock_defs.vh ***
`ifndef BOOT_LOCK_DEFS_VH
`define BOOT_LOCK_DEFS_VH
// Register byte offsets on the AXI4-Lite port.
`define ADDR_CONTROL     8'h00
`define ADDR_LOCKS       8'h04
`define ADDR_FUSE_LOW    8'h08
`define ADDR_FUSE_HIGH   8'h0c
`define ADDR_STATUS      8'h10
// Bit positions and reset value of progmem_control_reg.
`define CTL_STORE_EN     0
`define CTL_PAGE_ERASE   1
`define CTL_PAGE_WRITE   2
`define CTL_LOCK_SET     3
`define CTL_APP_READ_EN  4
`define CTL_APP_BUSY     6
`define CTL_RESET        5'h00
// Accepted low five bit patterns of the control register.
`define PAT_APP_READ_EN  5'h11
`define PAT_LOCK_SET     5'h09
`define PAT_PAGE_WRITE   5'h05
`define PAT_PAGE_ERASE   5'h03
`define PAT_BUFFER_LOAD  5'h01
// Window lengths in CPU clock cycles.
`define STORE_WINDOW_CYC 3'd4
`define LOAD_WINDOW_CYC  3'd5
// Boot lock field in the store data and its erased value.
`define LOCK_DATA_MSB    5
`define LOCK_DATA_LSB    2
`define LOCKS_ERASED     4'hf
// Readback pointer values.
`define RB_FUSE_LOW      16'h0000
`define RB_LOCKS         16'h0001
`define RB_FUSE_HIGH     16'h0003
// First word address of the boot section per boot size fuse pair.
`define BOOT_START_11    13'h1f80
`define BOOT_START_10    13'h1f00
`define BOOT_START_01    13'h1e00
`define BOOT_START_00    13'h1c00
// AXI responses.
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`endif

// *** hw/window_timer.v ***
`timescale 1ns/1ps
// Down counter that holds a request window open for LEN cycles after start.
module window_timer #(
  parameter [2:0] LEN = 3'd4
) (
  input  wire mclk,
  input  wire reset_n,
  input  wire start,
  input  wire stop,
  output wire open
);
  reg [2:0] count_r;

  // Start wins over stop so a re-arm in the closing cycle is kept.
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      count_r <= 3'd0;
    else if (start)
      count_r <= LEN;
    else if (stop)
      count_r <= 3'd0;
    else if (count_r != 3'd0)
      count_r <= count_r - 3'd1;
  end

  assign open = (count_r != 3'd0);
endmodule // window_timer

// *** hw/axi_lite_port.v ***
`timescale 1ns/1ps
`include "boot_lock_defs.vh"
// AXI4-Lite slave front end: one write and one read in flight at most.
module axi_lite_port (
  input  wire        mclk,
  input  wire        reset_n,
  input  wire        awvalid,
  output wire        awready,
  input  wire [7:0]  awaddr,
  input  wire        wvalid,
  output wire        wready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  output reg         bvalid,
  input  wire        bready,
  output reg  [1:0]  bresp,
  input  wire        arvalid,
  output wire        arready,
  input  wire [7:0]  araddr,
  output reg         rvalid,
  input  wire        rready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output wire        wrEn,
  output reg  [7:0]  wrAddr,
  output reg  [31:0] wrData,
  output reg  [3:0]  wrStrb,
  input  wire        wrErr,
  input  wire [31:0] rdData,
  input  wire        rdErr
);
  reg awHeld_r;
  reg wHeld_r;

  // Address and data are taken independently; no new ones until the response leaves.
  assign awready = !awHeld_r && !bvalid;
  assign wready  = !wHeld_r && !bvalid;
  assign arready = !rvalid;
  assign wrEn    = awHeld_r && wHeld_r;

  // Write path: commit one cycle after both halves are held.
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      wrAddr   <= 8'h00;
      wrData   <= 32'h00000000;
      wrStrb   <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= `RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_r <= 1'b1;
        wrAddr   <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHeld_r <= 1'b1;
        wrData  <= wdata;
        wrStrb  <= wstrb;
      end
      if (wrEn)
      begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= wrErr ? `RESP_SLVERR : `RESP_OKAY;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // Read path: data sampled from the register mux at the address edge.
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata  <= rdData;
      rresp  <= rdErr ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end
endmodule // axi_lite_port

// *** hw/boot_lock_guard.v ***
`timescale 1ns/1ps
`include "boot_lock_defs.vh"
module boot_lock_guard (
  input  wire        mclk,
  input  wire        reset_n,
  input  wire        awvalid,
  output wire        awready,
  input  wire [7:0]  awaddr,
  input  wire        wvalid,
  output wire        wready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  output wire        bvalid,
  input  wire        bready,
  output wire [1:0]  bresp,
  input  wire        arvalid,
  output wire        arready,
  input  wire [7:0]  araddr,
  output wire        rvalid,
  input  wire        rready,
  output wire [31:0] rdata,
  output wire [1:0]  rresp,
  input  wire        storeReq,
  input  wire        loadReq,
  input  wire [15:0] zPointer,
  input  wire [15:0] srcData,
  input  wire        execInBoot,
  input  wire        eepromWriteBusy,
  input  wire        flashOpDone,
  input  wire [3:0]  bootLockInit,
  input  wire [1:0]  generalLocks,
  input  wire [7:0]  fuseLowIn,
  input  wire [2:0]  fuseHighIn,
  input  wire        chipErase,
  input  wire        extLockProgram,
  input  wire [3:0]  extLockData,
  output reg         pageEraseCmd,
  output reg         pageWriteCmd,
  output reg         bufferLoadCmd,
  output reg  [6:0]  flashPageAddr,
  output reg  [5:0]  flashWordSel,
  output reg  [15:0] bufferData,
  output wire        loadOverride,
  output wire        loadRefused,
  output reg  [7:0]  loadData,
  output reg         loadDataValid,
  output reg         cpuHalt,
  output wire        irqDisable
);
  // One-hot sequencer states.
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_ARMED = 3'b010;
  localparam [2:0] ST_BUSY  = 3'b100;

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [4:0]  ctl_r;
  reg  [4:0]  ctl_nxt;
  reg  [3:0]  bootLocks_r;
  reg  [7:0]  fuseLow_r;
  reg  [2:0]  fuseHigh_r;
  reg         loaded_r;
  wire        wrEn;
  wire [7:0]  wrAddr;
  wire [31:0] wrData;
  wire [3:0]  wrStrb;
  reg         wrErr;
  reg  [31:0] rdData;
  reg         rdErr;
  wire        storeOpen;
  wire        loadOpen;
  wire        ctlWrite;
  wire        patternOk;
  wire        armStart;
  wire        windowStop;
  wire        storeTake;
  wire        loadTake;
  wire        targetBoot;
  wire        storeBlocked;
  wire        loadBlocked;
  wire        lockStore;
  wire        appWriteLock;
  wire        appReadLock;
  wire        bootWriteLock;
  wire        bootReadLock;
  reg  [7:0]  readback;

  // Lock bit order follows store data bits 5..2: boot read, boot write, app read, app write.
  assign appWriteLock  = bootLocks_r[0];
  assign appReadLock   = bootLocks_r[1];
  assign bootWriteLock = bootLocks_r[2];
  assign bootReadLock  = bootLocks_r[3];

  // True when a byte pointer falls in the boot section for the given size fuses.
  function isBoot;
    input [15:0] z;
    input [1:0]  size;
    reg   [12:0] start;
    begin
      case (size)
        2'b11:   start = `BOOT_START_11;
        2'b10:   start = `BOOT_START_10;
        2'b01:   start = `BOOT_START_01;
        default: start = `BOOT_START_00;
      endcase
      isBoot = (z[13:1] >= start);
    end
  endfunction

  axi_lite_port busPort (
    .mclk    (mclk),
    .reset_n (reset_n),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .wrEn    (wrEn),
    .wrAddr  (wrAddr),
    .wrData  (wrData),
    .wrStrb  (wrStrb),
    .wrErr   (wrErr),
    .rdData  (rdData),
    .rdErr   (rdErr)
  );

  window_timer #(.LEN(`STORE_WINDOW_CYC)) storeWindow (
    .mclk    (mclk),
    .reset_n (reset_n),
    .start   (armStart),
    .stop    (windowStop),
    .open    (storeOpen)
  );

  window_timer #(.LEN(`LOAD_WINDOW_CYC)) loadWindow (
    .mclk    (mclk),
    .reset_n (reset_n),
    .start   (armStart),
    .stop    (windowStop),
    .open    (loadOpen)
  );

  // Control writes need the low byte lane and an accepted pattern.
  assign ctlWrite  = wrEn && (wrAddr == `ADDR_CONTROL) && wrStrb[0];
  assign patternOk = (wrData[4:0] == `PAT_APP_READ_EN) ||
                     (wrData[4:0] == `PAT_LOCK_SET) ||
                     (wrData[4:0] == `PAT_PAGE_WRITE) ||
                     (wrData[4:0] == `PAT_PAGE_ERASE) ||
                     (wrData[4:0] == `PAT_BUFFER_LOAD);
  // A running erase or write and an EEPROM write both lock out re-arming.
  assign armStart  = ctlWrite && patternOk && !state_r[2] && !eepromWriteBusy;

  // Requests seen while the EEPROM is writing are never taken, though a locked-out load is still refused.
  assign storeTake = state_r[1] && storeReq && storeOpen && !eepromWriteBusy;
  assign loadTake  = state_r[1] && ctl_r[`CTL_LOCK_SET] && loadReq && loadOpen &&
                     !eepromWriteBusy;
  assign lockStore = storeTake && ctl_r[`CTL_LOCK_SET];

  // Target section checks; stores from application code are refused, except lock-bit stores.
  assign targetBoot   = isBoot(zPointer, fuseHigh_r[2:1]);
  assign storeBlocked = !execInBoot ||
                        (!targetBoot && !appWriteLock) ||
                        (targetBoot && !bootWriteLock);
  assign loadBlocked  = (execInBoot && !targetBoot && !appReadLock) ||
                        (!execInBoot && targetBoot && !bootReadLock);

  // Readback steals the load; otherwise locked-out loads are refused.
  assign loadOverride = loadTake;
  assign loadRefused  = loadReq && !loadTake && loadBlocked;
  assign irqDisable   = execInBoot && !bootReadLock;

  // The lock-set window runs to five cycles, every other pattern to four.
  assign windowStop = state_r[1] && !armStart &&
                      (storeTake || loadTake ||
                       (ctl_r[`CTL_LOCK_SET] ? !loadOpen : !storeOpen));

  // Readback byte by pointer; unused positions are driven as ones.
  always @*
  begin
    case (zPointer)
      `RB_FUSE_LOW:  readback = {fuseLow_r[7:5], 1'b1, fuseLow_r[3:0]};
      `RB_LOCKS:     readback = {2'b11, bootLocks_r, generalLocks};
      `RB_FUSE_HIGH: readback = {4'hf, 1'b1, fuseHigh_r};
      default:       readback = 8'hff;
    endcase
  end

  // Sequencer: arm on a control write, act on one request, then drop pending bits.
  always @*
  begin
    state_nxt = state_r;
    ctl_nxt   = ctl_r;
    case (state_r)
      ST_IDLE:
      begin
        if (armStart)
        begin
          state_nxt = ST_ARMED;
          ctl_nxt   = wrData[4:0];
        end
      end
      ST_ARMED:
      begin
        if (armStart)
          ctl_nxt = wrData[4:0];
        else if (storeTake && !storeBlocked &&
                 (ctl_r[`CTL_PAGE_ERASE] || ctl_r[`CTL_PAGE_WRITE]))
          state_nxt = ST_BUSY; // store enable stays high until the array finishes
        else if (windowStop)
        begin
          state_nxt = ST_IDLE;
          ctl_nxt   = `CTL_RESET;
        end
      end
      ST_BUSY:
      begin
        if (flashOpDone)
        begin
          state_nxt = ST_IDLE;
          ctl_nxt   = `CTL_RESET;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
        ctl_nxt   = `CTL_RESET;
      end
    endcase
  end

  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ST_IDLE;
      ctl_r   <= `CTL_RESET;
      cpuHalt <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      ctl_r   <= ctl_nxt;
      cpuHalt <= state_nxt[2];
    end
  end

  // Flash array commands; a refused store leaves the array alone.
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pageEraseCmd  <= 1'b0;
      pageWriteCmd  <= 1'b0;
      bufferLoadCmd <= 1'b0;
      flashPageAddr <= 7'h00;
      flashWordSel  <= 6'h00;
      bufferData    <= 16'h0000;
    end
    else
    begin
      pageEraseCmd  <= storeTake && !storeBlocked && ctl_r[`CTL_PAGE_ERASE];
      pageWriteCmd  <= storeTake && !storeBlocked && ctl_r[`CTL_PAGE_WRITE];
      bufferLoadCmd <= storeTake && !storeBlocked && (ctl_r == `PAT_BUFFER_LOAD);
      if (storeTake)
      begin
        flashPageAddr <= zPointer[13:7];
        flashWordSel  <= zPointer[6:1];
        bufferData    <= srcData;
      end
    end
  end

  // Readback result goes out one cycle after the load is taken.
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      loadData      <= 8'h00;
      loadDataValid <= 1'b0;
    end
    else
    begin
      loadDataValid <= loadTake;
      if (loadTake)
        loadData <= readback;
    end
  end

  // Nonvolatile state is taken from its inputs at the first edge after reset.
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      loaded_r    <= 1'b0;
      bootLocks_r <= `LOCKS_ERASED;
      fuseLow_r   <= 8'hff;
      fuseHigh_r  <= 3'h7;
    end
    else if (!loaded_r)
    begin
      loaded_r    <= 1'b1;
      bootLocks_r <= bootLockInit;
      fuseLow_r   <= fuseLowIn;
      fuseHigh_r  <= fuseHighIn;
    end
    else if (chipErase)
      bootLocks_r <= `LOCKS_ERASED;
    else if (extLockProgram)
      bootLocks_r <= bootLocks_r & extLockData;
    else if (lockStore)
      bootLocks_r <= bootLocks_r & srcData[`LOCK_DATA_MSB:`LOCK_DATA_LSB];
  end

  // Register read mux; the control busy bit and the reserved bits read as zero.
  always @*
  begin
    rdData = 32'h00000000;
    rdErr  = 1'b0;
    case (araddr)
      `ADDR_CONTROL:   rdData[4:0] = ctl_r;
      `ADDR_LOCKS:     rdData[5:0] = {bootLocks_r, generalLocks};
      `ADDR_FUSE_LOW:  rdData[7:0] = fuseLow_r;
      `ADDR_FUSE_HIGH: rdData[2:0] = fuseHigh_r;
      `ADDR_STATUS:    rdData[2:0] = {eepromWriteBusy, state_r[2], state_r[1]};
      default:         rdErr = 1'b1;
    endcase
  end

  // Read-only registers accept writes silently; unmapped ones answer an error.
  always @*
  begin
    case (wrAddr)
      `ADDR_CONTROL, `ADDR_LOCKS, `ADDR_FUSE_LOW, `ADDR_FUSE_HIGH, `ADDR_STATUS:
        wrErr = 1'b0;
      default:
        wrErr = 1'b1;
    endcase
  end
endmodule // boot_lock_guard

// *** tb/boot_lock_guard_props.sv ***
`timescale 1ns/1ps
module boot_lock_guard_props (
  input wire mclk,
  input wire reset_n,
  input wire bvalid,
  input wire storeReq,
  input wire loadReq,
  input wire execInBoot,
  input wire eepromWriteBusy,
  input wire loadOverride,
  input wire loadRefused,
  input wire loadDataValid,
  input wire bufferLoadCmd,
  input wire pageEraseCmd,
  input wire pageWriteCmd,
  input wire irqDisable
);
  reg        bvD_r;
  reg  [2:0] cnt_r;
  wire       rise = bvalid & ~bvD_r;
  wire [2:0] slot = rise ? 3'h1 : cnt_r;
  wire       anyCmd = bufferLoadCmd | pageEraseCmd | pageWriteCmd;

  // Cycles since a write took effect; saturating so a stale window never wraps.
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bvD_r <= 1'b0;
      cnt_r <= 3'h7;
    end
    else
    begin
      bvD_r <= bvalid;
      cnt_r <= rise ? 3'h2 : ((cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_loadSlot; loadOverride |-> slot >= 3'h1 && slot <= 3'h5; endproperty
  a_loadSlot: assert property (p_loadSlot) else $error("readback outside window");
  property p_storeSlot; anyCmd |-> slot >= 3'h2 && slot <= 3'h5; endproperty
  a_storeSlot: assert property (p_storeSlot) else $error("store outside window");
  property p_ldValid; loadOverride |=> loadDataValid; endproperty
  a_ldValid: assert property (p_ldValid) else $error("readback byte missing");
  property p_ldCause; loadDataValid |-> $past(loadOverride); endproperty
  a_ldCause: assert property (p_ldCause) else $error("readback byte unasked");
  property p_ovrReq; loadOverride |-> loadReq && !loadRefused; endproperty
  a_ovrReq: assert property (p_ovrReq) else $error("override without load");
  property p_eeLoad; eepromWriteBusy |-> !loadOverride; endproperty
  a_eeLoad: assert property (p_eeLoad) else $error("readback during eeprom write");
  property p_eeStore; storeReq && eepromWriteBusy |=> !anyCmd; endproperty
  a_eeStore: assert property (p_eeStore) else $error("store during eeprom write");
  property p_appCode; storeReq && !execInBoot |=> !anyCmd; endproperty
  a_appCode: assert property (p_appCode) else $error("store from application code");
  property p_irq; irqDisable |-> execInBoot; endproperty
  a_irq: assert property (p_irq) else $error("interrupts masked outside boot");
  property p_cmdCause; anyCmd |-> $past(storeReq); endproperty
  a_cmdCause: assert property (p_cmdCause) else $error("command without store");

  c_readback: cover property (loadDataValid);
  c_store: cover property (bufferLoadCmd);
  c_refused: cover property (loadRefused);
endmodule // boot_lock_guard_props

bind boot_lock_guard boot_lock_guard_props props (.*);

// *** tb/cpu_model.sv ***
`timescale 1ns/1ps
// Code running on the core, in the boot or the application section: one store or load per call.
module cpu_model (
  input  wire        mclk,
  input  wire        loadRefused,
  output reg         storeReq,
  output reg         loadReq,
  output reg  [15:0] zPointer,
  output reg  [15:0] srcData,
  output reg         execInBoot
);
  reg gotRef;

  // Idle core at time zero.
  initial
  begin
    storeReq = 1'b0;
    loadReq = 1'b0;
    zPointer = 16'h0000;
    srcData = 16'h0000;
    execInBoot = 1'b0;
    gotRef = 1'b0;
  end

  // Pointer and data are scrambled once used, so nothing stale looks held.
  task automatic issue(input st, input [15:0] z, input [15:0] d, input boot);
    begin
      storeReq <= st;
      loadReq <= !st;
      zPointer <= z;
      srcData <= d;
      execInBoot <= boot;
      @(posedge mclk);
      gotRef = loadRefused;
      storeReq <= 1'b0;
      loadReq <= 1'b0;
      zPointer <= ~z;
      srcData <= ~d;
      @(posedge mclk);
    end
  endtask
endmodule // cpu_model

// *** tb/boot_lock_guard_test.sv ***
`timescale 1ns/1ps
`include "boot_lock_defs.vh"
module boot_lock_guard_test;
  reg         mclk, reset_n, awvalid, wvalid, bready, arvalid, rready;
  reg  [7:0]  awaddr, araddr, fuseLowIn;
  reg  [31:0] wdata;
  reg  [3:0]  wstrb, bootLockInit, extLockData;
  reg  [1:0]  generalLocks;
  reg  [2:0]  fuseHighIn;
  reg         eepromWriteBusy, flashOpDone, chipErase, extLockProgram;
  wire        awready, wready, bvalid, arready, rvalid, cpuHalt, irqDisable;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire        storeReq, loadReq, execInBoot, loadOverride, loadRefused;
  wire [15:0] zPointer, srcData, bufferData;
  wire        pageEraseCmd, pageWriteCmd, bufferLoadCmd, loadDataValid;
  wire [6:0]  flashPageAddr;
  wire [5:0]  flashWordSel;
  wire [7:0]  loadData;
  int         num_errors = 0;
  int         n_compared = 0;
  reg  [15:0] expL[$];
  reg  [21:0] expB[$];
  reg  [8:0]  expP[$];
  reg  [15:0] m, lfsr;
  reg  [31:0] rd, e;
  reg  [1:0]  rr, br;

  boot_lock_guard DUT (.*);
  cpu_model cpu (.*);

  function automatic [15:0] nxt(input [15:0] v);
    nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      n_compared++;
      if (got !== exp)
      begin
        num_errors++;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task automatic close_out;
    begin
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  task automatic axw(input [7:0] a, input [31:0] d);
    int i;
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1; // Ready stays up between calls, so it never drops and rises in one step.
      for (i = 0; i < 40; i++)
      begin
        @(posedge mclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid === 1'b1) break;
      end
      br = bresp;
      if (i == 40) chk("write answer", 1, 0);
      if (i == 40) close_out();
    end
  endtask

  task automatic axr(input [7:0] a);
    int i;
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 40; i++)
      begin
        @(posedge mclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid === 1'b1) break;
      end
      rd = rdata;
      rr = rresp;
      if (i == 40) chk("read answer", 1, 0);
      if (i == 40) close_out();
    end
  endtask

  // Gap 0..3 puts the load in slots 2..5 of the window; 4 misses it.
  task automatic rdback(input [15:0] p, input [7:0] k, input [7:0] v, input int gap);
    begin
      axw(`ADDR_CONTROL, 32'h09);
      repeat (gap) @(posedge mclk);
      if (gap < 4 && !eepromWriteBusy) expL.push_back({k, v});
      cpu.issue(1'b0, p, lfsr, 1'b1);
    end
  endtask

  task automatic lockSet(input [3:0] v);
    begin
      axw(`ADDR_CONTROL, 32'h09);
      lfsr = nxt(lfsr);
      cpu.issue(1'b1, lfsr, {lfsr[15:6], v, 2'b11}, 1'b1);
    end
  endtask

  task automatic bufLoad(input [15:0] z, input ok);
    begin
      axw(`ADDR_CONTROL, 32'h01);
      lfsr = nxt(lfsr);
      if (ok) expB.push_back({z[6:1], lfsr});
      cpu.issue(1'b1, z, lfsr, 1'b1);
    end
  endtask

  // Erase or write halts the core until the array reports done; nothing is fetched meanwhile.
  task automatic pageOp(input [4:0] pat, input [15:0] z);
    begin
      axw(`ADDR_CONTROL, {27'h0, pat});
      expP.push_back({pat[1], pat[2], z[13:7]});
      cpu.issue(1'b1, z, lfsr, 1'b1);
      chk("halt while busy", 1, cpuHalt);
      axr(`ADDR_CONTROL);
      chk("control while busy", pat, rd[4:0]);
      flashOpDone <= 1'b1;
      @(posedge mclk);
      flashOpDone <= 1'b0;
      @(posedge mclk);
      chk("halt released", 0, cpuHalt);
    end
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Each result is paired with the oldest note; an unasked one meets an empty queue.
  always @(posedge mclk)
  begin
    if (loadDataValid === 1'b1)
    begin
      if (expL.size() == 0)
        chk("loadData unasked", 0, 1);
      else
      begin
        m = expL.pop_front();
        chk("loadData", m[7:0] & m[15:8], loadData & m[15:8]);
      end
    end
    // An empty queue yields a value wider than the port, so an unasked pulse always fails.
    if (bufferLoadCmd === 1'b1)
    begin
      e = (expB.size() > 0) ? expB.pop_front() : 32'h400000;
      chk("buffer word", e, {flashWordSel, bufferData});
    end
    if ((pageEraseCmd | pageWriteCmd) !== 1'b0)
    begin
      e = (expP.size() > 0) ? expP.pop_front() : 32'h200;
      chk("page command", e, {pageEraseCmd, pageWriteCmd, flashPageAddr});
    end
  end

  initial
  begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = 0;
    {eepromWriteBusy, flashOpDone, chipErase, extLockProgram, extLockData} = 0;
    wstrb = 4'hf;
    bootLockInit = 4'hf;
    generalLocks = 2'b10;
    fuseLowIn = 8'h6e;
    fuseHighIn = 3'b111;
    lfsr = 16'h000b;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    axr(`ADDR_LOCKS);
    chk("locks reg", 6'h3e, rd[5:0]);
    axr(`ADDR_FUSE_LOW);
    chk("fuse low reg", 8'h6e, rd[7:0]);
    axr(8'h20);
    chk("unmapped resp", `RESP_SLVERR, rr);
    axw(8'h20, 32'h0);
    chk("unmapped write resp", `RESP_SLVERR, br);
    rdback(`RB_FUSE_LOW, 8'hef, 8'h6e, 0);
    rdback(`RB_FUSE_HIGH, 8'h0f, 8'h0f, 3);
    rdback(`RB_LOCKS, 8'h3f, 8'h3e, 4);
    axr(`ADDR_CONTROL);
    chk("control after timeout", 7'h0, rd[6:0]);
    bufLoad(16'h0000, 1'b1);
    lockSet(4'b1100);
    rdback(`RB_LOCKS, 8'h3f, 8'h32, 1);
    lockSet(4'b1111);
    rdback(`RB_LOCKS, 8'h3f, 8'h32, 2);
    bufLoad(16'h0000, 1'b0);
    axr(`ADDR_CONTROL);
    chk("control after refusal", 5'h0, rd[4:0]);
    bufLoad(16'h3f02, 1'b1);
    cpu.issue(1'b0, 16'h0010, 16'h0000, 1'b1);
    chk("app read refused", 1, cpu.gotRef);
    lockSet(4'b0011);
    chk("irq masked in boot", 1, irqDisable);
    bufLoad(16'h3f04, 1'b0);
    cpu.issue(1'b0, 16'h3f00, 16'h0000, 1'b0);
    chk("boot read refused", 1, cpu.gotRef);
    chk("irq free in app", 0, irqDisable);
    eepromWriteBusy <= 1'b1;
    rdback(`RB_LOCKS, 8'h3f, 8'h02, 0);
    bufLoad(16'h3f02, 1'b0);
    eepromWriteBusy <= 1'b0;
    chipErase <= 1'b1;
    @(posedge mclk);
    chipErase <= 1'b0;
    axr(`ADDR_STATUS);
    chk("eeprom idle", 0, rd[2]);
    rdback(`RB_LOCKS, 8'h3f, 8'h3e, 0);
    // Stores from application code are refused yet still drop the pending bits.
    axw(`ADDR_CONTROL, 32'h01);
    cpu.issue(1'b1, 16'h0000, lfsr, 1'b0);
    axr(`ADDR_CONTROL);
    chk("control after app store", 0, rd[4:0]);
    pageOp(5'h03, 16'h0080);
    pageOp(5'h05, 16'h0100);
    axw(`ADDR_CONTROL, 32'h11);
    cpu.issue(1'b1, 16'h0000, lfsr, 1'b1);
    axr(`ADDR_STATUS);
    chk("busy after re-enable", 0, rd[1]);
    // Random patterns outside the accepted set must leave control idle.
    repeat (8)
    begin
      lfsr = nxt(lfsr);
      if (!(lfsr[4:0] inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01}))
      begin
        axw(`ADDR_CONTROL, {27'h0, lfsr[4:0]});
        axr(`ADDR_CONTROL);
        chk("control pattern", 5'h0, rd[4:0]);
        cpu.issue(1'b1, 16'h3f02, lfsr, 1'b1);
      end
    end
    repeat (3) @(posedge mclk);
    chk("loads left", 0, expL.size());
    chk("stores left", 0, expB.size());
    chk("pages left", 0, expP.size());
    close_out();
  end
endmodule // boot_lock_guard_test
